// ---- shared/scp_params.svh ----
/*
  Offsets, field positions, reset values and timing counts for the
  strap and serial modem pin block.
  Assumes inclusion by bare name from the package and design files.
*/
`ifndef SCP_PARAMS_SVH
`define SCP_PARAMS_SVH

`define SCP_OFS_CTRL1      8'h00
`define SCP_OFS_CTRL2      8'h04
`define SCP_OFS_STRAP      8'h08
`define SCP_OFS_MODEM      8'h0C
`define SCP_OFS_POWER      8'h10

`define SCP_CTRL_DTR       0
`define SCP_CTRL_RTS       1
`define SCP_CTRL_LOOP      4
`define SCP_CTRL_BAUD      7
`define SCP_CTRL_RESET     8'h00

`define SCP_PWR_SUPPLY     0
`define SCP_PWR_BUTTON     1
`define SCP_PWR_STBY0      2
`define SCP_PWR_STBY1      3
`define SCP_PWR_RESET      4'h0

`define SCP_STRAP_BASE     0
`define SCP_STRAP_PLC0     1
`define SCP_STRAP_PLC1     2
`define SCP_STRAP_POL      3
`define SCP_STRAP_TEST     4

`define SCP_BASE_LOW       8'h2E
`define SCP_BASE_HIGH      8'h4E

`define SCP_SETTLE_CYCLES  3'h4

`endif

// ---- shared/scp_pkg.sv ----
/*
  Types for the strap and serial modem pin block.
  Assumes scp_params.svh sits on the include path.
*/
`include "scp_params.svh"

package scp_pkg;

  typedef enum logic [2:0] {
    LD_SETTLE = 3'b001,
    LD_SAMPLE = 3'b010,
    LD_RUN    = 3'b100
  } scp_load_state_type;

  typedef logic [4:0] scp_strap_type;

endpackage

// ---- design/scp_strap_serial_pins.sv ----
/*
  Strap capture at the end of system reset and the modem control,
  serial output and power pins that share package pins with the straps,
  with an AHB-Lite register slave.
  Assumes a single 250 MHz clock, board pull resistors on strap pins,
  and UART cores on the same clock supplying tx data and baud clocks.
*/
// Local design decisions: the address map and the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "scp_params.svh"

module scp_strap_serial_pins (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic [31:0] hrdata,
  output var  logic        hreadyout,
  output var  logic        hresp,
  input  wire logic [1:0]  uartTx,
  input  wire logic [1:0]  baudClock,
  input  wire logic [4:0]  strapPinIn,
  output var  logic [4:0]  strapPinOut,
  output var  logic [4:0]  strapPinOe,
  input  wire logic [1:0]  ctsPinN,
  input  wire logic [1:0]  dcdPinN,
  input  wire logic [1:0]  dsrPinN,
  input  wire logic [1:0]  ringPinN,
  input  wire logic [1:0]  rxPin,
  input  wire logic        pin35In,
  input  wire logic        pin37In,
  output var  logic        pin33Out,
  output var  logic        pin33Oe,
  output var  logic        pin34Out,
  output var  logic        pin34Oe,
  output var  logic [7:0]  configIndexPort,
  output var  logic [7:0]  configDataPort,
  output var  logic        testMode
);
  import scp_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three stages, a change counts once 2 and 3 agree
  localparam int SW = 17;
  logic [SW-1:0] syncA_r, syncB_r, syncC_r, pinFilt_r;
  logic [SW-1:0] pinRaw;
  assign pinRaw = {rxPin, pin37In, pin35In, ringPinN, dsrPinN,
                   dcdPinN, ctsPinN, strapPinIn};

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      syncA_r   <= '1;
      syncB_r   <= '1;
      syncC_r   <= '1;
      pinFilt_r <= '1;
    end else begin
      syncA_r   <= pinRaw;
      syncB_r   <= syncA_r;
      syncC_r   <= syncB_r;
      pinFilt_r <= (syncB_r & syncC_r) | (pinFilt_r & (syncB_r ^ syncC_r));
    end
  end

  logic [1:0] ctsN, dcdN, dsrN, ringN;
  assign ctsN  = pinFilt_r[6:5];
  assign dcdN  = pinFilt_r[8:7];
  assign dsrN  = pinFilt_r[10:9];
  assign ringN = pinFilt_r[12:11];

  ////////////////////////////////////////////////////////////////////
  // Strap loader: waits for the filter to fill, then samples once
  scp_load_state_type ldState_r;
  logic [2:0]         settleCnt_r;
  scp_strap_type      strap_r;
  logic               running;
  assign running = (ldState_r == LD_RUN);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ldState_r   <= LD_SETTLE;
      settleCnt_r <= 3'h0;
    end else begin
      case (ldState_r)
        LD_SETTLE: begin
          settleCnt_r <= settleCnt_r + 3'h1;
          if (settleCnt_r == `SCP_SETTLE_CYCLES - 3'h1) begin
            ldState_r <= LD_SAMPLE;
          end
        end
        LD_SAMPLE: ldState_r <= LD_RUN;
        LD_RUN:    ldState_r <= LD_RUN;
        default:   ldState_r <= LD_SETTLE;
      endcase
    end
  end

  // single capture
  // Straps are taken once; later pin activity cannot disturb them
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      strap_r <= 5'h00;
    end else if (ldState_r == LD_SAMPLE) begin
      // Pin order differs from field order: base sits on pin 2
      strap_r <= {pinFilt_r[4], pinFilt_r[3], pinFilt_r[1], pinFilt_r[0], pinFilt_r[2]};
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      configIndexPort <= `SCP_BASE_LOW;
      configDataPort  <= `SCP_BASE_LOW + 8'h01;
      testMode        <= 1'b0;
    end else begin
      configIndexPort <= strap_r[`SCP_STRAP_BASE] ? `SCP_BASE_HIGH : `SCP_BASE_LOW;
      configDataPort  <= (strap_r[`SCP_STRAP_BASE] ? `SCP_BASE_HIGH : `SCP_BASE_LOW)
                         + 8'h01;
      testMode        <= strap_r[`SCP_STRAP_TEST];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // AHB-Lite slave, zero wait states, always OKAY
  logic [7:0]  ctrl_r [2];
  logic [3:0]  power_r;
  logic [1:0]  ringFlag_r;
  logic [1:0]  ringPrevN_r;
  logic        wrPend_r;
  logic [7:0]  wrAddr_r;
  logic        accept;
  assign accept = hsel && htrans[1] && hready;

  function automatic logic [31:0] read_word(input logic [7:0] a);
    case (a)
      `SCP_OFS_CTRL1: read_word = {24'h000000, ctrl_r[0]};
      `SCP_OFS_CTRL2: read_word = {24'h000000, ctrl_r[1]};
      `SCP_OFS_STRAP: read_word = {27'h0000000, strap_r};
      `SCP_OFS_MODEM: read_word = {18'h00000, pinFilt_r[16:13],
                                   ringFlag_r, ~ringN, ~dsrN, ~dcdN, ~ctsN};
      `SCP_OFS_POWER: read_word = {28'h0000000, power_r};
      default:        read_word = 32'h00000000;
    endcase
  endfunction

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wrPend_r  <= 1'b0;
      wrAddr_r  <= 8'h00;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wrPend_r <= accept && hwrite;
      wrAddr_r <= haddr[7:0];
      if (accept && !hwrite) begin
        hrdata <= read_word(haddr[7:0]);
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctrl_r[0] <= `SCP_CTRL_RESET;
      ctrl_r[1] <= `SCP_CTRL_RESET;
      power_r   <= `SCP_PWR_RESET;
    end else if (wrPend_r) begin
      case (wrAddr_r)
        `SCP_OFS_CTRL1: ctrl_r[0] <= hwdata[7:0];
        `SCP_OFS_CTRL2: ctrl_r[1] <= hwdata[7:0];
        `SCP_OFS_POWER: power_r   <= hwdata[3:0];
        default: ;
      endcase
    end
  end

  // ring latch
  // Set beats a write-one clear in the same cycle
  logic [1:0] ringEvent;
  logic [1:0] ringClr;
  assign ringEvent = ringPrevN_r & ~ringN;
  assign ringClr   = (wrPend_r && wrAddr_r == `SCP_OFS_MODEM) ? hwdata[9:8] : 2'b00;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ringPrevN_r <= 2'b11;
      ringFlag_r  <= 2'b00;
    end else begin
      ringPrevN_r <= ringN;
      ringFlag_r  <= ringEvent | (ringFlag_r & ~ringClr);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Shared serial pins: 0/1 tx, 2/3 DTR, 4 RTS1
  logic [4:0] pinOut_nxt;
  logic [4:0] pinOe_nxt;

  always_comb begin
    pinOut_nxt = 5'h1F;
    pinOe_nxt  = 5'h00;
    if (running) begin
      pinOe_nxt = 5'h1F;
      for (int ch = 0; ch < 2; ch++) begin
        pinOut_nxt[ch] = ctrl_r[ch][`SCP_CTRL_LOOP] | uartTx[ch];
        if (ctrl_r[ch][`SCP_CTRL_BAUD]) begin
          pinOut_nxt[2+ch] = baudClock[ch];
        end else begin
          pinOut_nxt[2+ch] = ctrl_r[ch][`SCP_CTRL_LOOP] | ~ctrl_r[ch][`SCP_CTRL_DTR];
        end
      end
      pinOut_nxt[4] = ctrl_r[0][`SCP_CTRL_LOOP] | ~ctrl_r[0][`SCP_CTRL_RTS];
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      strapPinOut <= 5'h1F;
      strapPinOe  <= 5'h00;
    end else begin
      strapPinOut <= pinOut_nxt;
      strapPinOe  <= pinOe_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Power and standby pins 33 and 34
  logic pin33Out_nxt, pin33Oe_nxt, pin34Out_nxt, pin34Oe_nxt;
  logic supplyOn;
  assign supplyOn = power_r[`SCP_PWR_SUPPLY];

  always_comb begin
    pin33Out_nxt = 1'b1;
    pin33Oe_nxt  = 1'b0;
    pin34Out_nxt = 1'b1;
    pin34Oe_nxt  = 1'b0;
    if (running) begin
      if (strap_r[`SCP_STRAP_PLC0]) begin
        pin33Out_nxt = power_r[`SCP_PWR_STBY0];
        pin33Oe_nxt  = 1'b1;
        pin34Out_nxt = power_r[`SCP_PWR_STBY1];
        pin34Oe_nxt  = 1'b1;
      end else begin
        pin33Out_nxt = 1'b0;
        pin33Oe_nxt  = power_r[`SCP_PWR_BUTTON];
        if (strap_r[`SCP_STRAP_POL]) begin
          pin34Out_nxt = supplyOn;
          pin34Oe_nxt  = 1'b1;
        end else begin
          pin34Out_nxt = 1'b0;
          pin34Oe_nxt  = supplyOn;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pin33Out <= 1'b1;
      pin33Oe  <= 1'b0;
      pin34Out <= 1'b1;
      pin34Oe  <= 1'b0;
    end else begin
      pin33Out <= pin33Out_nxt;
      pin33Oe  <= pin33Oe_nxt;
      pin34Out <= pin34Out_nxt;
      pin34Oe  <= pin34Oe_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  chk_base_port: assert property (
    running |=> configIndexPort ==
      ($past(strap_r[`SCP_STRAP_BASE]) ? `SCP_BASE_HIGH : `SCP_BASE_LOW))
    else $error("config port pair does not follow base strap");

  chk_test_strap: assert property (
    running |=> testMode == $past(strap_r[`SCP_STRAP_TEST]))
    else $error("test mode does not follow test strap");

  chk_strap_hold: assert property (
    running && $past(running) |-> $stable(strap_r))
    else $error("strap changed after capture");

  chk_undriven_early: assert property (
    !running |=> strapPinOe == 5'h00 && !pin34Oe && !pin33Oe)
    else $error("shared pin driven before strap capture");

  chk_dtr_loop: assert property (
    running && ctrl_r[0][`SCP_CTRL_LOOP] && !ctrl_r[0][`SCP_CTRL_BAUD]
      |=> strapPinOut[2] && strapPinOe[2])
    else $error("DTR1 active during loopback");

  chk_baud_route: assert property (
    running && ctrl_r[1][`SCP_CTRL_BAUD] |=> strapPinOut[3] == $past(baudClock[1]))
    else $error("DTR2 does not carry baud clock");

  chk_rts_idle: assert property (
    $rose(running) |-> ##1 (strapPinOut[4] && strapPinOe[4]) [*2])
    else $error("RTS1 not inactive after reset");

  chk_tx_mark: assert property (
    running && ctrl_r[0][`SCP_CTRL_LOOP] |=> strapPinOut[0])
    else $error("serial output not at mark in loopback");

  chk_supply_od: assert property (
    running && !strap_r[`SCP_STRAP_PLC0] && !strap_r[`SCP_STRAP_POL] && supplyOn
      |=> pin34Oe && !pin34Out)
    else $error("open-drain supply-on not pulled low");

  chk_ring_sticky: assert property (
    ringEvent[0] |=> ringFlag_r[0])
    else $error("ring event lost");

  cov_loopback: cover property (running && ctrl_r[0][`SCP_CTRL_LOOP]);
  cov_baud_test: cover property (running && ctrl_r[1][`SCP_CTRL_BAUD]);
  cov_ring: cover property (ringEvent[1]);
  cov_supply_on: cover property (running && pin34Oe && supplyOn);

endmodule
`default_nettype wire

// ---- sim/scp_board_model.sv ----
/*
  Board side of the strap pins: pull resistors and a modem.
  Assumes the bench picks the resistor fitting and modem state.
*/
`timescale 1ns/100ps
`default_nettype none
module scp_board_model (
  input  wire logic [4:0] strapPull,
  input  wire logic [4:0] pinOut,
  input  wire logic [4:0] pinOe,
  input  wire logic       modemReady,
  input  wire logic       ringOn,
  output var  logic [4:0] pinLevel,
  output var  logic [1:0] ctsN,
  output var  logic [1:0] dcdN,
  output var  logic [1:0] dsrN,
  output var  logic [1:0] ringN
);
  // Released pins go to the resistor level
  always_comb pinLevel = (pinOe & pinOut) | (~pinOe & strapPull);
  always_comb ctsN = modemReady ? 2'h0 : 2'h3;
  always_comb dcdN = modemReady ? 2'h0 : 2'h3;
  always_comb dsrN = modemReady ? 2'h0 : 2'h3;
  // Ring shown as a low pulse
  always_comb ringN = ringOn ? 2'h0 : 2'h3;
endmodule
`default_nettype wire

// ---- sim/tb_top.sv ----
/*
  Bench for the strap and modem pin block: AHB-Lite tasks and checks.
  Assumes the board model file is compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
`include "scp_params.svh"
module tb_top;
  logic clock = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]  htrans = 2'h0, uartTx = 2'h3, baudClock = 2'h0, rxPin = 2'h3;
  logic [2:0]  hsize = 3'h2;
  logic [4:0]  strapPull = 5'h0, pinIn, pinOut, pinOe;
  logic [1:0]  ctsN, dcdN, dsrN, ringN;
  logic        hready, hresp, modemReady = 1'b0, ringOn = 1'b0;
  logic        p33, p33Oe, p34, p34Oe, testMode;
  logic [7:0]  cfgIdx, cfgDat;
  logic [4:0]  s, sr;
  logic [4:0]  tbl [3] = '{5'h00, 5'h1E, 5'h15};
  int          mismatches = 0, testsRun = 0;
  always #2 clock = ~clock;
  scp_strap_serial_pins dut (.clock(clock), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .uartTx(uartTx),
    .baudClock(baudClock), .strapPinIn(pinIn), .strapPinOut(pinOut), .strapPinOe(pinOe),
    .ctsPinN(ctsN), .dcdPinN(dcdN), .dsrPinN(dsrN), .ringPinN(ringN), .rxPin(rxPin),
    .pin35In(1'b1), .pin37In(1'b1), .pin33Out(p33), .pin33Oe(p33Oe), .pin34Out(p34),
    .pin34Oe(p34Oe), .configIndexPort(cfgIdx), .configDataPort(cfgDat),
    .testMode(testMode));
  scp_board_model board (.strapPull(strapPull), .pinOut(pinOut), .pinOe(pinOe),
    .modemReady(modemReady), .ringOn(ringOn), .pinLevel(pinIn), .ctsN(ctsN),
    .dcdN(dcdN), .dsrN(dsrN), .ringN(ringN));
  //////////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stopTest();
    $display("checks=%0d mismatches=%0d", testsRun, mismatches);
    if (mismatches == 0 && testsRun > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic waitClk(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic busXfer(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w; hsize <= 3'h2;
    do @(posedge clock); while (hready !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge clock); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic doReset(input logic [4:0] pull);
    @(posedge clock);
    resetn <= 1'b0; strapPull <= pull;
    waitClk(20);
    chk({pinOe, p33Oe, p34Oe}, 32'h0);
    resetn <= 1'b1;
    waitClk(12);
  endtask
  //////////////////////////////////////////////////////////////////////////////////////
  initial begin
    for (int i = 0; i < 3; i++) begin
      s = tbl[i];
      sr = {s[4], s[3], s[1], s[0], s[2]};
      doReset(s);
      chk({cfgIdx, cfgDat}, s[2] ? 16'h4E4F : 16'h2E2F);
      chk(testMode, s[4]);
      chk({pinOe, pinOut}, 10'h3FF);
      if (!s[0]) begin
        busXfer(`SCP_OFS_POWER, 1'b1, 32'h3);
        waitClk(2);
        chk({p33Oe, p33, p34Oe, p34}, {3'b101, s[3]});
        busXfer(`SCP_OFS_POWER, 1'b1, 32'h0);
        waitClk(2);
        chk({p34Oe, p34}, {s[3], 1'b0});
      end else begin
        busXfer(`SCP_OFS_POWER, 1'b1, 32'hC);
        waitClk(2);
        chk({p33Oe, p33, p34Oe, p34}, 4'hF);
      end
      busXfer(`SCP_OFS_STRAP, 1'b0, 32'h0);
      chk(rd, sr);
    end
    uartTx <= 2'h2;
    busXfer(`SCP_OFS_CTRL1, 1'b1, 32'h3);
    waitClk(2);
    chk({pinOut[4], pinOut[2], pinOut[1:0]}, 4'h2);
    busXfer(`SCP_OFS_CTRL1, 1'b1, 32'h13);
    waitClk(2);
    chk({pinOut[4], pinOut[2]}, 2'h3);
    busXfer(`SCP_OFS_CTRL1, 1'b1, 32'h83);
    busXfer(`SCP_OFS_CTRL2, 1'b1, 32'h81);
    for (int b = 0; b < 4; b++) begin
      baudClock <= b[1:0];
      waitClk(2);
      chk({pinOut[3], pinOut[2]}, b[1:0]);
    end
    busXfer(`SCP_OFS_STRAP, 1'b0, 32'h0);
    chk(rd, sr);
    modemReady <= 1'b1;
    waitClk(8);
    busXfer(`SCP_OFS_MODEM, 1'b0, 32'h0);
    chk(rd[5:0], 6'h3F);
    chk(rd[13:10], 4'hF);
    ringOn <= 1'b1;
    waitClk(8);
    ringOn <= 1'b0;
    waitClk(8);
    busXfer(`SCP_OFS_MODEM, 1'b0, 32'h0);
    chk(rd[9:8], 2'h3);
    busXfer(`SCP_OFS_MODEM, 1'b1, 32'h300);
    busXfer(`SCP_OFS_MODEM, 1'b0, 32'h0);
    chk(rd[9:8], 2'h0);
    busXfer(32'h20, 1'b1, 32'hFF);
    busXfer(32'h20, 1'b0, 32'h0);
    chk({rd, hresp}, 33'h0);
    stopTest();
  end
  // Whole run needs well under 2000 cycles
  initial begin
    waitClk(20000);
    mismatches++;
    stopTest();
  end
endmodule
`default_nettype wire
